// >>> pdsc_pkg.sv
// Constants and carrier types for the sink capabilities / request format checker.
// Assumes one APB slave on a 32-bit bus with byte addresses in paddr.
package pdsc_pkg;

    localparam int PDSC_AW = 8;
    localparam int PDSC_OBJ_W = 3;
    localparam int PDSC_OBJ_N = 8;

    // Register byte offsets
    localparam logic [PDSC_AW-1:0] PDSC_OFF_CTRL = 8'h00;
    localparam logic [PDSC_AW-1:0] PDSC_OFF_SRC_CNT = 8'h04;
    localparam logic [PDSC_AW-1:0] PDSC_OFF_FAIL = 8'h08;
    localparam logic [PDSC_AW-1:0] PDSC_OFF_STAT = 8'h0c;
    localparam logic [2:0] PDSC_PAGE_SNK_EXP = 3'h1;
    localparam logic [2:0] PDSC_PAGE_SRC_PDO = 3'h2;

    // Control register field positions
    localparam int PDSC_CTRL_ENABLE = 0;
    localparam int PDSC_CTRL_MODE_REQ = 1;
    localparam int PDSC_CTRL_EXT_KNOWN = 2;
    localparam int PDSC_CTRL_EXT_PWR = 3;
    localparam int PDSC_CTRL_DUAL_ROLE = 4;
    localparam int PDSC_CTRL_HIGHER_CAP = 5;
    localparam int PDSC_CTRL_USB_COMM = 6;
    localparam int PDSC_CTRL_DR_SWAP = 7;
    localparam int PDSC_CTRL_NO_SUSPEND = 8;
    localparam int PDSC_CTRL_W = 9;
    localparam logic [PDSC_CTRL_W-1:0] PDSC_CTRL_RST = 9'h000;

    // Message header and object codes
    localparam logic [3:0] PDSC_MT_SNK_CAP = 4'h4;
    localparam logic [3:0] PDSC_MT_REQUEST = 4'h2;
    localparam logic [1:0] PDSC_PDO_FIXED = 2'h0;
    localparam logic [1:0] PDSC_PDO_BATTERY = 2'h1;
    localparam logic [1:0] PDSC_PDO_VARIABLE = 2'h2;
    localparam logic [1:0] PDSC_PDO_BAD = 2'h3;
    // 5 V in 50 mV steps
    localparam logic [9:0] PDSC_VOLT_5V = 10'h064;

    typedef struct packed {
        logic hdr;
        logic [31:0] word;
    } pdsc_beat_t;

    // One sticky flag per check; sc_count is bit 0
    typedef struct packed {
        logic rq_bat_gb;
        logic rq_bat_nogb;
        logic rq_cur_gb;
        logic rq_cur_nogb;
        logic rq_resv;
        logic rq_pos;
        logic rq_b31;
        logic rq_type;
        logic rq_count;
        logic sc_dup;
        logic sc_var_bat;
        logic sc_fixed_val;
        logic sc_fixed_resv;
        logic sc_order;
        logic sc_bad_type;
        logic sc_first_cur;
        logic sc_first_volt;
        logic sc_first_resv;
        logic sc_first_flags;
        logic sc_first_fixed;
        logic sc_type;
        logic sc_count;
    } pdsc_fail_t;

    localparam int PDSC_FAIL_W = $bits(pdsc_fail_t);

endpackage : pdsc_pkg

// >>> pdsc_checker.sv
// Format checker for sink capabilities and request messages of the unit under test.
// Assumes message beats arrive synchronous to pclk: one header beat, then data objects.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps

module pdsc_checker
    import pdsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PDSC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic msg_valid,
    input wire pdsc_beat_t msg_beat,
    output logic fail_any
);

    logic [PDSC_CTRL_W-1:0] ctrl_r;
    logic [PDSC_OBJ_W-1:0] src_cnt_r;
    pdsc_fail_t fail_r;
    pdsc_fail_t fail_set;
    logic [15:0] hdr_r;
    logic [7:0] msg_cnt_r;
    logic [PDSC_OBJ_W-1:0] idx_r;
    logic [PDSC_OBJ_W:0] left_r;
    logic [31:0] snk_exp_r [PDSC_OBJ_N];
    logic [31:0] src_pdo_r [PDSC_OBJ_N];
    logic [31:0] objs_r [PDSC_OBJ_N];
    logic [31:0] rdata_r;
    logic err_r;

    // Bus decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire [2:0] page = paddr[7:5];
    wire [PDSC_OBJ_W-1:0] tidx = paddr[4:2];
    wire hit_ctrl = paddr == PDSC_OFF_CTRL;
    wire hit_src_cnt = paddr == PDSC_OFF_SRC_CNT;
    wire hit_fail = paddr == PDSC_OFF_FAIL;
    wire hit_stat = paddr == PDSC_OFF_STAT;
    wire hit_snk = page == PDSC_PAGE_SNK_EXP && paddr[1:0] == 2'h0;
    wire hit_src = page == PDSC_PAGE_SRC_PDO && paddr[1:0] == 2'h0;
    wire hit_any = hit_ctrl || hit_src_cnt || hit_fail || hit_stat || hit_snk || hit_src;
    wire [31:0] stat_word = {msg_cnt_r, 5'h00, idx_r, hdr_r};
    logic [31:0] rd_mux;

    always_comb begin
        if (hit_ctrl) begin
            rd_mux = {{(32-PDSC_CTRL_W){1'b0}}, ctrl_r};
        end else if (hit_src_cnt) begin
            rd_mux = {{(32-PDSC_OBJ_W){1'b0}}, src_cnt_r};
        end else if (hit_fail) begin
            rd_mux = {{(32-PDSC_FAIL_W){1'b0}}, fail_r};
        end else if (hit_stat) begin
            rd_mux = stat_word;
        end else if (hit_snk) begin
            rd_mux = snk_exp_r[tidx];
        end else if (hit_src) begin
            rd_mux = src_pdo_r[tidx];
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    assign pready = 1'b1;
    assign prdata = rdata_r;
    assign pslverr = psel && penable && err_r;

    // Message framing
    wire enable = ctrl_r[PDSC_CTRL_ENABLE];
    wire mode_req = ctrl_r[PDSC_CTRL_MODE_REQ];
    wire [31:0] w = msg_beat.word;
    wire is_hdr = enable && msg_valid && msg_beat.hdr;
    wire is_obj = enable && msg_valid && !msg_beat.hdr && left_r != '0;
    wire [2:0] h_cnt = w[14:12];
    wire [3:0] h_type = w[3:0];
    wire snk_obj = is_obj && !mode_req;
    wire req_obj = is_obj && mode_req;

    // Sink object fields
    wire [1:0] typ = w[31:30];
    wire [9:0] volt = w[19:10];
    wire [9:0] cur = w[9:0];
    wire [31:0] exp_w = snk_exp_r[idx_r];
    wire first = idx_r == '0;
    wire [PDSC_OBJ_W-1:0] pidx = idx_r - 1'b1;
    wire [31:0] prev_w = objs_r[pidx];
    wire [1:0] rank = {typ == PDSC_PDO_VARIABLE, typ == PDSC_PDO_BATTERY};
    wire [1:0] prank = {prev_w[31:30] == PDSC_PDO_VARIABLE, prev_w[31:30] == PDSC_PDO_BATTERY};
    wire [9:0] pvolt = prev_w[19:10];
    wire is_fixed = typ == PDSC_PDO_FIXED;
    wire is_vb = typ == PDSC_PDO_VARIABLE || typ == PDSC_PDO_BATTERY;
    wire [4:0] first_flags = {ctrl_r[PDSC_CTRL_DUAL_ROLE], ctrl_r[PDSC_CTRL_HIGHER_CAP],
        ctrl_r[PDSC_CTRL_EXT_PWR], ctrl_r[PDSC_CTRL_USB_COMM], ctrl_r[PDSC_CTRL_DR_SWAP]};
    wire [4:0] flag_mask = {2'b11, ctrl_r[PDSC_CTRL_EXT_KNOWN], 2'b11};
    wire flags_bad = ((w[29:25] ^ first_flags) & flag_mask) != 5'h00;
    wire order_bad = !first && (rank < prank || (rank == prank && volt <= pvolt));

    // Compare against every earlier object of the same type
    logic [PDSC_OBJ_N-1:0] dup_hit;
    genvar gj;
    generate
        for (gj = 0; gj < PDSC_OBJ_N; gj++) begin : g_dup
            wire older = gj < idx_r;
            wire same_type = objs_r[gj][31:30] == typ;
            wire same_v = objs_r[gj][19:10] == volt;
            wire same_rng = objs_r[gj][29:10] == w[29:10];
            assign dup_hit[gj] = older && same_type && (is_fixed ? same_v : same_rng);
        end
    endgenerate

    // Request fields and referenced offer
    wire [2:0] pos = w[30:28];
    wire pos_bad = pos == 3'h0 || pos > src_cnt_r;
    wire [31:0] offer_w = src_pdo_r[pos - 3'h1];
    wire [9:0] offer = offer_w[9:0];
    wire offer_bat = offer_w[31:30] == PDSC_PDO_BATTERY;
    wire [9:0] opv = w[19:10];
    wire [9:0] lim = w[9:0];
    wire giveback = w[27];
    wire mismatch = w[26];
    wire nogb_bad = opv > offer || opv > lim || (lim > offer && !mismatch);
    wire gb_bad = opv > offer || lim > offer || lim > opv;
    wire lim_ok = req_obj && !pos_bad;
    wire [1:0] req_flags = {ctrl_r[PDSC_CTRL_USB_COMM], ctrl_r[PDSC_CTRL_NO_SUSPEND]};

    always_comb begin
        fail_set = '0;
        fail_set.sc_count = is_hdr && !mode_req && h_cnt == 3'h0;
        fail_set.sc_type = is_hdr && !mode_req && h_type != PDSC_MT_SNK_CAP;
        fail_set.rq_count = is_hdr && mode_req && h_cnt != 3'h1;
        fail_set.rq_type = is_hdr && mode_req && h_type != PDSC_MT_REQUEST;
        fail_set.sc_first_fixed = snk_obj && first && !is_fixed;
        fail_set.sc_first_flags = snk_obj && first && flags_bad;
        fail_set.sc_first_resv = snk_obj && first && w[24:20] != 5'h00;
        fail_set.sc_first_volt = snk_obj && first && volt != PDSC_VOLT_5V;
        fail_set.sc_first_cur = snk_obj && first && cur > exp_w[9:0];
        fail_set.sc_bad_type = snk_obj && typ == PDSC_PDO_BAD;
        fail_set.sc_order = snk_obj && order_bad;
        fail_set.sc_fixed_resv = snk_obj && !first && is_fixed && w[29:20] != 10'h000;
        fail_set.sc_fixed_val = snk_obj && is_fixed && !first && volt != exp_w[19:10];
        if (snk_obj && is_fixed && cur > exp_w[9:0]) begin
            fail_set.sc_fixed_val = 1'b1;
        end
        fail_set.sc_var_bat = snk_obj && is_vb && (w[29:10] != exp_w[29:10]
            || cur > exp_w[9:0]);
        fail_set.sc_dup = snk_obj && dup_hit != '0;
        fail_set.rq_b31 = req_obj && w[31];
        fail_set.rq_pos = req_obj && pos_bad;
        fail_set.rq_resv = req_obj && (w[25:24] != req_flags || w[23:20] != 4'h0);
        fail_set.rq_cur_nogb = lim_ok && !offer_bat && !giveback && nogb_bad;
        fail_set.rq_cur_gb = lim_ok && !offer_bat && giveback && gb_bad;
        fail_set.rq_bat_nogb = lim_ok && offer_bat && !giveback && nogb_bad;
        fail_set.rq_bat_gb = lim_ok && offer_bat && giveback && gb_bad;
    end

    // Hardware set wins over a same-cycle software clear
    wire fail_clr_en = wr_en && hit_fail;
    wire [PDSC_FAIL_W-1:0] fail_clr = fail_clr_en ? pwdata[PDSC_FAIL_W-1:0] : '0;
    wire [PDSC_FAIL_W-1:0] fail_nxt = (fail_r & ~fail_clr) | fail_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_r <= '0;
            fail_any <= 1'b0;
        end else begin
            fail_r <= fail_nxt;
            fail_any <= fail_nxt != '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else if (setup) begin
            rdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            err_r <= !hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= PDSC_CTRL_RST;
            src_cnt_r <= '0;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata[PDSC_CTRL_W-1:0];
            end
            if (hit_src_cnt) begin
                src_cnt_r <= pwdata[PDSC_OBJ_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PDSC_OBJ_N; i++) begin
                snk_exp_r[i] <= 32'h0000_0000;
                src_pdo_r[i] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            if (hit_snk) begin
                snk_exp_r[tidx] <= pwdata;
            end
            if (hit_src) begin
                src_pdo_r[tidx] <= pwdata;
            end
        end
    end

    // Header starts a message; objects beyond the header count are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_r <= 16'h0000;
            msg_cnt_r <= 8'h00;
            idx_r <= '0;
            left_r <= '0;
        end else if (is_hdr) begin
            hdr_r <= w[15:0];
            msg_cnt_r <= msg_cnt_r + 8'h01;
            idx_r <= '0;
            left_r <= {1'b0, h_cnt};
        end else if (is_obj) begin
            idx_r <= idx_r + 1'b1;
            left_r <= left_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PDSC_OBJ_N; i++) begin
                objs_r[i] <= 32'h0000_0000;
            end
        end else if (is_obj) begin
            objs_r[idx_r] <= w;
        end
    end

endmodule : pdsc_checker

// >>> pdsc_properties.sv
// Concurrent checks on the ports of the sink capabilities / request format checker.
// Assumes CTRL is written only through APB at its byte offset and beats come on pclk.
`timescale 1ns/1ps

module pdsc_properties
    import pdsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PDSC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic msg_valid,
    input wire pdsc_beat_t msg_beat,
    input wire logic fail_any
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic en_r;
    logic req_r;
    wire acc = psel && penable;
    wire map_ok = (paddr < 8'h10) || (paddr >= 8'h20 && paddr < 8'h60);
    wire clr = acc && pwrite && paddr == PDSC_OFF_FAIL;
    wire hdr = msg_valid && msg_beat.hdr && en_r;
    wire obj = msg_valid && !msg_beat.hdr;
    wire [2:0] cnt = msg_beat.word[14:12];

    // Shadow of enable and mode, updated at the same access edge as the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            req_r <= 1'b0;
        end else if (acc && pwrite && paddr == PDSC_OFF_CTRL) begin
            en_r <= pwdata[PDSC_CTRL_ENABLE];
            req_r <= pwdata[PDSC_CTRL_MODE_REQ];
        end
    end

    sequence s_snk_hdr;
        hdr && !req_r && cnt != 3'h0;
    endsequence
    sequence s_req_hdr;
        hdr && req_r && cnt == 3'h1;
    endsequence

    AST_READY: assert property (acc |-> pready) else $error("no ready in access");
    AST_ERR_IDLE: assert property (!acc |-> !pslverr) else $error("error outside access");
    AST_UNMAP_ERR: assert property (acc && !map_ok |-> pslverr) else $error("no error");
    AST_UNMAP_RD: assert property (acc && !pwrite && !map_ok |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_FAIL_HOLD: assert property (fail_any && !clr |=> fail_any)
        else $error("fail flag lost");
    AST_FAIL_CAUSE: assert property ($rose(fail_any) |-> $past(msg_valid))
        else $error("fail without beat");
    AST_SNK_COUNT: assert property (hdr && !req_r && cnt == 3'h0 |=> fail_any)
        else $error("zero count passed");
    AST_SNK_TYPE: assert property (hdr && !req_r && msg_beat.word[3:0] != PDSC_MT_SNK_CAP
        |=> fail_any) else $error("sink type passed");
    AST_REQ_COUNT: assert property (hdr && req_r && cnt != 3'h1 |=> fail_any)
        else $error("request count passed");
    AST_REQ_TYPE: assert property (hdr && req_r && msg_beat.word[3:0] != PDSC_MT_REQUEST
        |=> fail_any) else $error("request type passed");
    AST_SNK_BAD: assert property (s_snk_hdr ##1 obj && msg_beat.word[31:30] == PDSC_PDO_BAD
        |=> fail_any) else $error("type 11b passed");
    AST_REQ_B31: assert property (s_req_hdr ##1 obj && msg_beat.word[31] |=> fail_any)
        else $error("bit 31 passed");
    AST_REQ_POS: assert property (s_req_hdr ##1 obj && msg_beat.word[30:28] == 3'h0
        |=> fail_any) else $error("position zero passed");
endmodule : pdsc_properties

bind pdsc_checker pdsc_properties u_pdsc_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_valid(msg_valid), .msg_beat(msg_beat), .fail_any(fail_any)
);

// >>> pdsc_uut_model.sv
// Model of the unit under test: sends a header beat, then objects back to back.
// Assumes the bench calls send after reset and waits for it to return.
`timescale 1ns/1ps

module pdsc_uut_model
    import pdsc_pkg::*;
(
    input wire logic pclk,
    output logic msg_valid,
    output pdsc_beat_t msg_beat
);
    initial begin
        msg_valid = 1'b0;
        msg_beat = '0;
    end

    // Data lines show the inverted last word once released
    task automatic send(input logic [15:0] h, input logic [31:0] o [3], input int n);
        @(posedge pclk);
        msg_valid <= 1'b1;
        msg_beat <= '{hdr: 1'b1, word: {16'h0000, h}};
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            msg_beat <= '{hdr: 1'b0, word: o[i]};
        end
        @(posedge pclk);
        msg_valid <= 1'b0;
        msg_beat.word <= ~msg_beat.word;
    endtask : send
endmodule : pdsc_uut_model

// >>> pd_sink_cap_request_checker_tb.sv
// Self-checking bench: APB master plus message source around the format checker.
// Assumes zero-wait APB and the FAIL bit map of the design package.
`timescale 1ns/1ps

module pd_sink_cap_request_checker_tb;
    import pdsc_pkg::*;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [PDSC_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic msg_valid;
    pdsc_beat_t msg_beat;
    logic fail_any;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #2.5 pclk = ~pclk;

    pdsc_checker u_pdsc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid),
        .msg_beat(msg_beat), .fail_any(fail_any));
    pdsc_uut_model u_pdsc_uut_model (.pclk(pclk), .msg_valid(msg_valid),
        .msg_beat(msg_beat));

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Clear flags, send one message, compare the flags it left
    task automatic m(input logic [15:0] h, input logic [31:0] a, b, c, input int n,
        input logic [31:0] e);
        apb(1'b1, PDSC_OFF_FAIL, 32'h003fffff);
        u_pdsc_uut_model.send(h, '{a, b, c}, n);
        apb(1'b0, PDSC_OFF_FAIL, 32'h0);
        chk(rd, e);
    endtask : m

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PDSC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h20, 32'h00019096);
        apb(1'b1, 8'h24, 32'h000320c8);
        apb(1'b1, 8'h28, 32'h12c320c8);
        apb(1'b1, 8'h40, 32'h00019096);
        apb(1'b1, 8'h44, 32'h40000028);
        apb(1'b1, PDSC_OFF_SRC_CNT, 32'h2);
        m(16'h0044, 32'hc0000000, 0, 0, 1, 32'h0);
        apb(1'b1, PDSC_OFF_CTRL, 32'h1);
        m(16'h1044, 32'h00019064, 0, 0, 1, 32'h0);
        m(16'h0044, 32'h00019064, 0, 0, 1, 32'h1);
        m(16'h1045, 32'h00019064, 0, 0, 1, 32'h2);
        m(16'h1044, 32'h80019064, 0, 0, 1, 32'h4);
        m(16'h1044, 32'h20019064, 0, 0, 1, 32'h8);
        m(16'h1044, 32'h00119064, 0, 0, 1, 32'h10);
        m(16'h1044, 32'h0001a064, 0, 0, 1, 32'h20);
        m(16'h1044, 32'hc0019064, 0, 0, 1, 32'h84);
        m(16'h1044, 32'h00019097, 0, 0, 1, 32'h440);
        chk({31'h0, fail_any}, 32'h1);
        m(16'h3044, 32'h00019064, 32'h00032064, 32'h52c32064, 3, 32'h0);
        m(16'h2044, 32'h00019064, 32'h00132064, 0, 2, 32'h200);
        m(16'h3044, 32'h00019064, 32'h00032064, 32'h52c320c9, 3, 32'h800);
        apb(1'b1, 8'h24, 32'h12c320c8);
        apb(1'b1, 8'h28, 32'h000320c8);
        m(16'h3044, 32'h00019064, 32'h52c32064, 32'h00032064, 3, 32'h100);
        apb(1'b1, 8'h24, 32'h000320c8);
        m(16'h3044, 32'h00019064, 32'h00032064, 32'h00032064, 3, 32'h1100);
        m(16'h2044, 32'h00019064, 32'h0003e864, 0, 2, 32'h400);
        apb(1'b1, PDSC_OFF_CTRL, 32'hd);
        m(16'h1044, 32'h00019064, 0, 0, 1, 32'h8);
        m(16'h1044, 32'h08019064, 0, 0, 1, 32'h0);
        apb(1'b1, PDSC_OFF_CTRL, 32'h3);
        m(16'h1042, 32'h10019064, 0, 0, 1, 32'h0);
        m(16'h2042, 32'h10019064, 0, 0, 1, 32'h2000);
        m(16'h1043, 32'h10019064, 0, 0, 1, 32'h4000);
        m(16'h1042, 32'h90019064, 0, 0, 1, 32'h8000);
        m(16'h1042, 32'h00019064, 0, 0, 1, 32'h10000);
        m(16'h1042, 32'h30019064, 0, 0, 1, 32'h10000);
        m(16'h1042, 32'h10119064, 0, 0, 1, 32'h20000);
        m(16'h1042, 32'h12019064, 0, 0, 1, 32'h20000);
        m(16'h1042, 32'h10025c97, 0, 0, 1, 32'h40000);
        m(16'h1042, 32'h14019097, 0, 0, 1, 32'h0);
        m(16'h1042, 32'h18019065, 0, 0, 1, 32'h80000);
        m(16'h1042, 32'h2000a029, 0, 0, 1, 32'h100000);
        m(16'h1042, 32'h2800a428, 0, 0, 1, 32'h200000);
        m(16'h1042, 32'h2800a028, 0, 0, 1, 32'h0);
        apb(1'b1, PDSC_OFF_CTRL, 32'h143);
        m(16'h1042, 32'h13019064, 0, 0, 1, 32'h0);
        m(16'h1042, 32'h10019064, 0, 0, 1, 32'h20000);
        stop_test();
    end
endmodule : pd_sink_cap_request_checker_tb
